/* File: logic/hco_top.sv */
// Purpose: Hardware cursor overlay with lockable control registers
// Assumes: Raster position and active size arrive with each pixel
// Notes:   Pixel latency is two clocks for every pixel, cursor or not
`default_nettype none

// Summary of operation
// - Convention bit four selects first or alternate
// - Cursor is 64 by 64 from memory
// - Shape is 512-byte AND then XOR masks
// - First convention truth table incl. inversion
// - Alternate: AND zero passes, else colours
// - Two three-byte colour stacks, one location each
// - Mode read resets stack pointers, writes fill
// - Legacy display mode forces cursor off
// - Enhanced mode: mode bit zero enables cursor
// - Unlock with A0H, relock with 00H
// - X and Y are 11-bit, split high/low
// - Clip right and bottom, hide below height
// - Y offset shows bottom 64 minus OY rows
// - X offset shows right 64 minus OX columns
// - Offsets are six-bit fields, bits five-zero
// - Position takes effect once per frame
// - Fetch 512 AND then 512 XOR bytes
// - Start address is 1 KB segment index
module hco_top #(
  parameter int PIX_W = 24
) (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  nrst_in,
  // Register port
  input  wire logic [7:0]            reg_idx_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [7:0]            reg_wdata_in,
  output logic [7:0]                 reg_rdata_out,
  // Display mode status
  input  wire logic                  enhanced_in,
  input  wire logic                  legacy_mode_in,
  // Raster
  input  wire logic                  frame_start_in,
  input  wire logic [10:0]           scr_x_in,
  input  wire logic [10:0]           scr_y_in,
  input  wire logic [10:0]           act_width_in,
  input  wire logic [10:0]           act_height_in,
  input  wire logic [PIX_W-1:0]      pix_in,
  output logic [PIX_W-1:0]           pix_out,
  // Display memory
  output logic                       mem_req_out,
  output logic [21:0]                mem_addr_out,
  input  wire logic                  mem_ack_in,
  input  wire logic [7:0]            mem_data_in
);

  if (PIX_W != 8 && PIX_W != 16 && PIX_W != 24) begin : g_chk
    $error("PIX_W must be 8, 16 or 24");
  end

  // ==========================================================
  // Helpers
  // Returns {hit, index}: hit when scr falls inside the visible span starting at pos
  function automatic logic [6:0] span_hit(input logic [10:0] scr, input logic [10:0] pos,
                                          input logic [5:0] off, input logic [10:0] lim);
    logic [10:0] d;
    logic        hit;
    d   = scr - pos;
    hit = (scr >= pos) && (d < (11'(hco_pkg::CUR_SIZE) - {5'h00, off})) && (scr < lim);
    return {hit, 6'(d[5:0] + off)};
  endfunction

  // ==========================================================
  // Control registers
  logic [7:0]  lock_q;
  logic [7:0]  mode_q;
  logic [7:0]  conv_q;
  logic [7:0]  fg_q [0:2];
  logic [7:0]  bg_q [0:2];
  logic [1:0]  fg_ptr_q;
  logic [1:0]  bg_ptr_q;
  logic [3:0]  start_hi_q;
  logic [7:0]  start_lo_q;
  logic [2:0]  x_hi_q;
  logic [7:0]  x_lo_q;
  logic [2:0]  y_hi_q;
  logic [7:0]  y_lo_q;
  logic [5:0]  x_offset_value_q;
  logic [5:0]  y_offset_value_q;
  logic [7:0]  rd_d;

  wire unlocked  = (lock_q == hco_pkg::UNLOCK_KEY);
  wire wr_ok     = reg_wr_in && (unlocked || reg_idx_in == hco_pkg::IDX_LOCK);
  wire wr_lock   = reg_wr_in && (reg_idx_in == hco_pkg::IDX_LOCK);
  wire wr_mode   = wr_ok && (reg_idx_in == hco_pkg::IDX_MODE);
  wire wr_conv   = wr_ok && (reg_idx_in == hco_pkg::IDX_CONV);
  wire wr_fg     = wr_ok && (reg_idx_in == hco_pkg::IDX_FG_STACK);
  wire wr_bg     = wr_ok && (reg_idx_in == hco_pkg::IDX_BG_STACK);
  wire rd_mode   = reg_rd_in && (reg_idx_in == hco_pkg::IDX_MODE);
  wire wr_st_hi  = wr_ok && (reg_idx_in == hco_pkg::IDX_START_HI);
  wire wr_st_lo  = wr_ok && (reg_idx_in == hco_pkg::IDX_START_LO);
  wire wr_x_hi   = wr_ok && (reg_idx_in == hco_pkg::IDX_X_HIGH);
  wire wr_x_lo   = wr_ok && (reg_idx_in == hco_pkg::IDX_X_LOW);
  wire wr_y_hi   = wr_ok && (reg_idx_in == hco_pkg::IDX_Y_HIGH);
  wire wr_y_lo   = wr_ok && (reg_idx_in == hco_pkg::IDX_Y_LOW);
  wire wr_x_off  = wr_ok && (reg_idx_in == hco_pkg::IDX_X_OFFSET);
  wire wr_y_off  = wr_ok && (reg_idx_in == hco_pkg::IDX_Y_OFFSET);
  wire [1:0] fg_ptr_nx = (fg_ptr_q == hco_pkg::STACK_LAST) ? 2'h0 : fg_ptr_q + 2'h1;
  wire [1:0] bg_ptr_nx = (bg_ptr_q == hco_pkg::STACK_LAST) ? 2'h0 : bg_ptr_q + 2'h1;

  // The lock register itself is always writable, otherwise software could never unlock
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_q <= hco_pkg::LOCK_KEY;
    end else if (wr_lock) begin
      lock_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q           <= hco_pkg::RST_BYTE;
      conv_q           <= hco_pkg::RST_BYTE;
      start_hi_q       <= '0;
      start_lo_q       <= hco_pkg::RST_BYTE;
      x_hi_q           <= '0;
      x_lo_q           <= hco_pkg::RST_BYTE;
      y_hi_q           <= '0;
      y_lo_q           <= hco_pkg::RST_BYTE;
      x_offset_value_q <= '0;
      y_offset_value_q <= '0;
    end else begin
      if (wr_mode)  mode_q           <= reg_wdata_in;
      if (wr_conv)  conv_q           <= reg_wdata_in;
      if (wr_st_hi) start_hi_q       <= reg_wdata_in[3:0];
      if (wr_st_lo) start_lo_q       <= reg_wdata_in;
      if (wr_x_hi)  x_hi_q           <= reg_wdata_in[2:0];
      if (wr_x_lo)  x_lo_q           <= reg_wdata_in;
      if (wr_y_hi)  y_hi_q           <= reg_wdata_in[2:0];
      if (wr_y_lo)  y_lo_q           <= reg_wdata_in;
      if (wr_x_off) x_offset_value_q <= reg_wdata_in[5:0];
      if (wr_y_off) y_offset_value_q <= reg_wdata_in[5:0];
    end
  end

  // Colour stacks: pointer advances low, second, third byte and wraps
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fg_ptr_q <= '0;
      bg_ptr_q <= '0;
      fg_q     <= '{default: hco_pkg::RST_BYTE};
      bg_q     <= '{default: hco_pkg::RST_BYTE};
    end else begin
      if (rd_mode) begin
        fg_ptr_q <= '0;
        bg_ptr_q <= '0;
      end
      if (wr_fg) begin
        fg_q[fg_ptr_q] <= reg_wdata_in;
        fg_ptr_q       <= fg_ptr_nx;
      end
      if (wr_bg) begin
        bg_q[bg_ptr_q] <= reg_wdata_in;
        bg_ptr_q       <= bg_ptr_nx;
      end
    end
  end

  // ==========================================================
  // Read-back
  always_comb begin
    case (reg_idx_in)
      hco_pkg::IDX_LOCK:     rd_d = lock_q;
      hco_pkg::IDX_MODE:     rd_d = mode_q;
      hco_pkg::IDX_CONV:     rd_d = conv_q;
      hco_pkg::IDX_FG_STACK: rd_d = fg_q[fg_ptr_q];
      hco_pkg::IDX_BG_STACK: rd_d = bg_q[bg_ptr_q];
      hco_pkg::IDX_START_HI: rd_d = {4'h0, start_hi_q};
      hco_pkg::IDX_START_LO: rd_d = start_lo_q;
      hco_pkg::IDX_X_HIGH:   rd_d = {5'h00, x_hi_q};
      hco_pkg::IDX_X_LOW:    rd_d = x_lo_q;
      hco_pkg::IDX_Y_HIGH:   rd_d = {5'h00, y_hi_q};
      hco_pkg::IDX_Y_LOW:    rd_d = y_lo_q;
      hco_pkg::IDX_X_OFFSET: rd_d = {2'h0, x_offset_value_q};
      hco_pkg::IDX_Y_OFFSET: rd_d = {2'h0, y_offset_value_q};
      default:               rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_d;
    end
  end

  // ==========================================================
  // Frame-latched geometry
  // Latching at frame start keeps a half-written high/low pair from tearing the cursor
  logic [10:0] cur_x_q;
  logic [10:0] cur_y_q;
  logic [5:0]  cur_ox_q;
  logic [5:0]  cur_oy_q;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_x_q  <= '0;
      cur_y_q  <= '0;
      cur_ox_q <= '0;
      cur_oy_q <= '0;
    end else if (frame_start_in) begin
      cur_x_q  <= {x_hi_q, x_lo_q};
      cur_y_q  <= {y_hi_q, y_lo_q};
      cur_ox_q <= x_offset_value_q;
      cur_oy_q <= y_offset_value_q;
    end
  end

  // ==========================================================
  // Pixel pipeline stage 0: window and mask address
  wire [6:0] hx     = span_hit(scr_x_in, cur_x_q, cur_ox_q, act_width_in);
  wire [6:0] hy     = span_hit(scr_y_in, cur_y_q, cur_oy_q, act_height_in);
  wire       cur_en = mode_q[hco_pkg::MODE_EN_BIT] && enhanced_in && !legacy_mode_in;
  wire       win_s0 = cur_en && hx[6] && hy[6];
  wire [8:0] rd_adr = {hy[5:0], hx[5:3]};

  // Stage 1: mask bytes arrive from the shape store
  logic             win_s1_q;
  logic [2:0]       bit_s1_q;
  logic [PIX_W-1:0] pix_s1_q;
  logic [7:0]       and_byte;
  logic [7:0]       xor_byte;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      win_s1_q <= 1'b0;
      bit_s1_q <= '0;
      pix_s1_q <= '0;
    end else begin
      win_s1_q <= win_s0;
      bit_s1_q <= hx[2:0];
      pix_s1_q <= pix_in;
    end
  end

  // Leftmost pixel of a byte is its most significant bit
  wire       and_bit = and_byte[3'h7 - bit_s1_q];
  wire       xor_bit = xor_byte[3'h7 - bit_s1_q];
  wire [23:0] fg_col = {fg_q[2], fg_q[1], fg_q[0]};
  wire [23:0] bg_col = {bg_q[2], bg_q[1], bg_q[0]};

  hco_shape_fetch u_fetch (
    .ref_clk_in     (ref_clk_in),
    .nrst_in        (nrst_in),
    .frame_start_in (frame_start_in),
    .seg_in         ({start_hi_q, start_lo_q}),
    .mem_req_out    (mem_req_out),
    .mem_addr_out   (mem_addr_out),
    .mem_ack_in     (mem_ack_in),
    .mem_data_in    (mem_data_in),
    .rd_addr_in     (rd_adr),
    .and_byte_out   (and_byte),
    .xor_byte_out   (xor_byte)
  );

  hco_mixer #(.PIX_W(PIX_W)) u_mix (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .pix_in       (pix_s1_q),
    .in_cursor_in (win_s1_q),
    .alt_conv_in  (conv_q[hco_pkg::CONV_BIT]),
    .and_bit_in   (and_bit),
    .xor_bit_in   (xor_bit),
    .fg_in        (fg_col[PIX_W-1:0]),
    .bg_in        (bg_col[PIX_W-1:0]),
    .pix_out      (pix_out)
  );

  // ==========================================================
  // Checks
  property p_locked_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (reg_wr_in && !unlocked && reg_idx_in != hco_pkg::IDX_LOCK) |=> ($stable(mode_q) && $stable(x_lo_q));
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("write accepted while locked");

  property p_stack_reset;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      rd_mode |=> (fg_ptr_q == 2'h0 && bg_ptr_q == 2'h0);
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("mode read did not reset stacks");

  property p_pos_hold;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !frame_start_in |=> ($stable(cur_x_q) && $stable(cur_y_q));
  endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("position changed mid-frame");

  property p_legacy_off;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      legacy_mode_in |-> ##2 (pix_out == $past(pix_in, 2));
  endproperty
  a_legacy_off: assert property (p_legacy_off) else $error("cursor shown in legacy mode");

  property p_outside_pass;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !win_s0 |-> ##2 (pix_out == $past(pix_in, 2));
  endproperty
  a_outside_pass: assert property (p_outside_pass) else $error("pixel outside cursor altered");

  property p_below_height;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (scr_y_in >= act_height_in || scr_x_in >= act_width_in) |-> !win_s0;
  endproperty
  a_below_height: assert property (p_below_height) else $error("cursor outside active area");

  property p_x_span;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      win_s0 |-> ((scr_x_in - cur_x_q) < (11'd64 - {5'h00, cur_ox_q}) && hx[5:0] >= cur_ox_q);
  endproperty
  a_x_span: assert property (p_x_span) else $error("column outside offset span");

endmodule

`default_nettype wire

/* File: logic/hco_pkg.sv */
// Purpose: Shared constants for the hardware cursor overlay
// Assumes: 8-bit index/data register port, 40 MHz pixel-rate clock
// Notes:   Register indices follow the device's extended control space
`default_nettype none

package hco_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_LOCK     = 8'h39;
  localparam logic [7:0] IDX_MODE     = 8'h45;
  localparam logic [7:0] IDX_X_HIGH   = 8'h46;
  localparam logic [7:0] IDX_X_LOW    = 8'h47;
  localparam logic [7:0] IDX_Y_HIGH   = 8'h48;
  localparam logic [7:0] IDX_Y_LOW    = 8'h49;
  localparam logic [7:0] IDX_FG_STACK = 8'h4A;
  localparam logic [7:0] IDX_BG_STACK = 8'h4B;
  localparam logic [7:0] IDX_START_HI = 8'h4C;
  localparam logic [7:0] IDX_START_LO = 8'h4D;
  localparam logic [7:0] IDX_X_OFFSET = 8'h4E;
  localparam logic [7:0] IDX_Y_OFFSET = 8'h4F;
  localparam logic [7:0] IDX_CONV     = 8'h55;

  // ==========================================================
  // Field positions and key values
  localparam int         MODE_EN_BIT  = 0;
  localparam int         CONV_BIT     = 4;
  localparam logic [7:0] UNLOCK_KEY   = 8'hA0;
  localparam logic [7:0] LOCK_KEY     = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] STACK_LAST   = 2'h2;

  // ==========================================================
  // Cursor geometry and shape store
  localparam int         CUR_SIZE     = 64;
  localparam int         POS_W        = 11;
  localparam int         OFF_W        = 6;
  localparam int         SEG_W        = 12;
  localparam int         MASK_BYTES   = 512;
  localparam int         SHAPE_BYTES  = 1024;
  localparam int         BYTE_AW      = 10;
  localparam int         MASK_AW      = 9;
  localparam int         PIPE_DEPTH   = 2;

endpackage

`default_nettype wire

/* File: logic/hco_shape_fetch.sv */
// Purpose: Fetches the cursor AND and XOR masks once per frame and serves bytes
// Assumes: Memory answers each request with one byte and a one-cycle ack
// Notes:   Read port has one cycle of latency for both masks
`default_nettype none

module hco_shape_fetch (
  // Clock and reset
  input  wire logic                              ref_clk_in,
  input  wire logic                              nrst_in,
  // Control
  input  wire logic                              frame_start_in,
  input  wire logic [hco_pkg::SEG_W-1:0]         seg_in,
  // Display memory
  output logic                                   mem_req_out,
  output logic [hco_pkg::SEG_W+hco_pkg::BYTE_AW-1:0] mem_addr_out,
  input  wire logic                              mem_ack_in,
  input  wire logic [7:0]                        mem_data_in,
  // Pixel-side read port
  input  wire logic [hco_pkg::MASK_AW-1:0]       rd_addr_in,
  output logic [7:0]                             and_byte_out,
  output logic [7:0]                             xor_byte_out
);

  typedef enum logic {HCO_IDLE, HCO_RUN} hco_fetch_e;

  hco_fetch_e                       state_q;
  logic [hco_pkg::SEG_W-1:0]        seg_q;
  logic [hco_pkg::BYTE_AW-1:0]      cnt_q;
  logic [7:0]                       and_mem [0:hco_pkg::MASK_BYTES-1];
  logic [7:0]                       xor_mem [0:hco_pkg::MASK_BYTES-1];
  wire                              take  = (state_q == HCO_RUN) && mem_ack_in;
  wire                              last  = (cnt_q == hco_pkg::BYTE_AW'(hco_pkg::SHAPE_BYTES - 1));

  // ==========================================================
  // Fetch sequencer
  // A new frame start during a fetch is ignored so a frame never sees a half-loaded shape twice
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q     <= HCO_IDLE;
      seg_q       <= '0;
      cnt_q       <= '0;
      mem_req_out <= 1'b0;
    end else begin
      case (state_q)
        HCO_IDLE: begin
          if (frame_start_in) begin
            state_q     <= HCO_RUN;
            seg_q       <= seg_in;
            cnt_q       <= '0;
            mem_req_out <= 1'b1;
          end
        end
        HCO_RUN: begin
          if (mem_ack_in) begin
            if (last) begin
              state_q     <= HCO_IDLE;
              mem_req_out <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        default: state_q <= HCO_IDLE;
      endcase
    end
  end

  // Segment index times 1024 plus byte count gives a contiguous 1 KB block
  assign mem_addr_out = {seg_q, cnt_q};

  // ==========================================================
  // Shape store: lower half of the block is AND, upper half XOR
  always_ff @(posedge ref_clk_in) begin
    if (take && !cnt_q[hco_pkg::MASK_AW]) begin
      and_mem[cnt_q[hco_pkg::MASK_AW-1:0]] <= mem_data_in;
    end
    if (take && cnt_q[hco_pkg::MASK_AW]) begin
      xor_mem[cnt_q[hco_pkg::MASK_AW-1:0]] <= mem_data_in;
    end
    and_byte_out <= and_mem[rd_addr_in];
    xor_byte_out <= xor_mem[rd_addr_in];
  end

  property p_fetch_base;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (state_q == HCO_IDLE && frame_start_in) |=> (mem_req_out && mem_addr_out == {$past(seg_in), 10'h000});
  endproperty
  a_fetch_base: assert property (p_fetch_base) else $error("fetch does not start at segment base");

  property p_fetch_step;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (take && !last) |=> (mem_req_out && mem_addr_out == $past(mem_addr_out) + 1'b1);
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch address not consecutive");

endmodule

`default_nettype wire

/* File: logic/hco_mixer.sv */
// Purpose: Combines one cursor mask bit pair with the screen pixel
// Assumes: Inputs are aligned to the same pixel
// Notes:   One register stage; its output is the overlay's pixel output
`default_nettype none

module hco_mixer #(
  parameter int PIX_W = 24
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  // Pixel and cursor inputs
  input  wire logic [PIX_W-1:0] pix_in,
  input  wire logic             in_cursor_in,
  input  wire logic             alt_conv_in,
  input  wire logic             and_bit_in,
  input  wire logic             xor_bit_in,
  input  wire logic [PIX_W-1:0] fg_in,
  input  wire logic [PIX_W-1:0] bg_in,
  // Result
  output logic [PIX_W-1:0]      pix_out
);

  wire [PIX_W-1:0] std_pix = !and_bit_in ? (xor_bit_in ? fg_in : bg_in)
                           : (xor_bit_in ? ~pix_in : pix_in);
  wire [PIX_W-1:0] alt_pix = !and_bit_in ? pix_in
                           : (xor_bit_in ? fg_in : bg_in);
  wire [PIX_W-1:0] cur_pix = alt_conv_in ? alt_pix : std_pix;
  wire [PIX_W-1:0] mix_d   = in_cursor_in ? cur_pix : pix_in;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pix_out <= '0;
    end else begin
      pix_out <= mix_d;
    end
  end

  property p_std_invert;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (in_cursor_in && !alt_conv_in && and_bit_in && xor_bit_in) |=> (pix_out == ~$past(pix_in));
  endproperty
  a_std_invert: assert property (p_std_invert) else $error("first convention did not invert");

  property p_std_colour;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (in_cursor_in && !alt_conv_in && !and_bit_in) |=> (pix_out == ($past(xor_bit_in) ? $past(fg_in) : $past(bg_in)));
  endproperty
  a_std_colour: assert property (p_std_colour) else $error("first convention colour wrong");

  property p_alt_pass;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (in_cursor_in && alt_conv_in && !and_bit_in) |=> (pix_out == $past(pix_in));
  endproperty
  a_alt_pass: assert property (p_alt_pass) else $error("alternate convention did not pass pixel");

  property p_alt_fg;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (in_cursor_in && alt_conv_in && and_bit_in && xor_bit_in) |=> (pix_out == $past(fg_in));
  endproperty
  a_alt_fg: assert property (p_alt_fg) else $error("alternate convention foreground wrong");

endmodule

`default_nettype wire

/* File: verif/hco_top_tb.sv */
// Purpose: Self-checking bench for the hardware cursor overlay
// Assumes: Two-clock pixel latency, one-clock read latency
// Notes:   Memory answers every other cycle; shape bytes are random except one padded byte column
`default_nettype none

module hco_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and reference model state
  typedef struct {logic [23:0] v; int age;} hco_note_s;
  logic        ref_clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0, frame_start_in = 0;
  logic        enhanced_in = 1, legacy_mode_in = 0, mem_ack_in = 0, mem_req_out, men = 0, conv = 0;
  logic [7:0]  reg_idx_in = 0, reg_wdata_in = 0, mem_data_in = 0, reg_rdata_out;
  logic [10:0] scr_x_in = 0, scr_y_in = 0, act_width_in = 11'h064, act_height_in = 11'h032;
  logic [23:0] pix_in = 0, pix_out, fg = 24'hC3B2A1, bg = 24'h1D2E3F;
  logic [21:0] mem_addr_out;
  logic [7:0]  shape [1024];
  hco_note_s   pq [$], rq [$];
  int          num_errors = 0, check_count = 0, seed = 62946, nbytes = 0;
  int          px, py, pox, poy, lx, ly, lox, loy;

  hco_top u_dut (.ref_clk_in, .nrst_in, .reg_idx_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .enhanced_in, .legacy_mode_in, .frame_start_in, .scr_x_in, .scr_y_in, .act_width_in, .act_height_in,
    .pix_in, .pix_out, .mem_req_out, .mem_addr_out, .mem_ack_in, .mem_data_in);

  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================
  // Checking
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Notes age on falling edges so outputs are compared when settled
  always @(negedge ref_clk_in) begin
    foreach (pq[i]) pq[i].age++;
    foreach (rq[i]) rq[i].age++;
    if (pq.size() > 0 && pq[0].age == 3) begin
      chk(pix_out, pq[0].v);
      void'(pq.pop_front());
    end
    if (rq.size() > 0 && rq[0].age == 2) begin
      chk({16'h0000, reg_rdata_out}, rq[0].v);
      void'(rq.pop_front());
    end
  end

  // Display memory: one byte per ack, address checked on every request
  always @(posedge ref_clk_in) begin
    if (mem_req_out === 1'b1 && !mem_ack_in) begin
      mem_ack_in  <= 1'b1;
      mem_data_in <= shape[mem_addr_out[9:0]];
      chk({2'h0, mem_addr_out}, {2'h0, 12'h3FE, 10'(nbytes)});
      nbytes <= nbytes + 1;
    end else begin
      mem_ack_in <= 1'b0;
    end
  end

  function automatic logic [23:0] expect_pix(int x, int y, logic [23:0] p);
    int r, c, b;
    logic a, xo;
    if (!(men && enhanced_in && !legacy_mode_in) || x < lx || y < ly || x - lx >= 64 - lox || y - ly >= 64 - loy
        || x >= 100 || y >= 50) return p;
    r = y - ly + loy;
    c = x - lx + lox;
    b = r * 8 + c / 8;
    a = shape[b][7 - c % 8];
    xo = shape[512 + b][7 - c % 8];
    if (conv) return a ? (xo ? fg : bg) : p;
    return a ? (xo ? ~p : p) : (xo ? fg : bg);
  endfunction

  // ==========================================================
  // Drivers
  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_idx_in <= i;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task rd(input logic [7:0] i, input logic [23:0] e);
    @(posedge ref_clk_in);
    reg_idx_in <= i;
    reg_rd_in <= 1'b1;
    rq.push_back('{e, 0});
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
  endtask

  task scan();
    logic [23:0] p;
    for (int y = 38; y <= 52; y++) for (int x = 66; x <= 104; x++) begin
      @(posedge ref_clk_in);
      p = 24'($random(seed));
      scr_x_in <= 11'(x);
      scr_y_in <= 11'(y);
      pix_in <= p;
      pq.push_back('{expect_pix(x, y, p), 0});
    end
    repeat (4) @(posedge ref_clk_in);
  endtask

  task frame();
    @(negedge ref_clk_in);
    nbytes = 0;
    @(posedge ref_clk_in);
    frame_start_in <= 1'b1;
    @(posedge ref_clk_in);
    frame_start_in <= 1'b0;
    lx = px;
    ly = py;
    lox = pox;
    loy = poy;
    for (int i = 0; i < 3000 && nbytes < 1024; i++) @(posedge ref_clk_in);
    if (nbytes < 1024) begin
      num_errors++;
      $display("[FAIL] %0t shape fetch did not finish", $time);
      stop_test();
    end
    repeat (4) @(posedge ref_clk_in);
    chk({23'h000000, mem_req_out}, 24'h000000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    foreach (shape[i]) shape[i] = 8'($random(seed));
    // One byte column padded as a transparent area for the first convention, as software does for small cursors
    for (int r = 0; r < 64; r++) begin
      shape[r * 8 + 3]       = 8'hFF;
      shape[512 + r * 8 + 3] = 8'h00;
    end
    repeat (5) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd(hco_pkg::IDX_MODE, 24'h000000);
    wr(hco_pkg::IDX_MODE, 8'h01);
    rd(hco_pkg::IDX_MODE, 24'h000000);
    wr(hco_pkg::IDX_LOCK, hco_pkg::UNLOCK_KEY);
    wr(hco_pkg::IDX_MODE, 8'h01);
    wr(hco_pkg::IDX_X_HIGH, 8'hF8);
    wr(hco_pkg::IDX_X_LOW, 8'h46);
    wr(hco_pkg::IDX_Y_LOW, 8'h28);
    wr(hco_pkg::IDX_X_OFFSET, 8'hC3);
    wr(hco_pkg::IDX_Y_OFFSET, 8'h05);
    wr(hco_pkg::IDX_START_HI, 8'hF3);
    wr(hco_pkg::IDX_START_LO, 8'hFE);
    wr(hco_pkg::IDX_FG_STACK, 8'h11);
    rd(hco_pkg::IDX_MODE, 24'h000001);
    for (int i = 0; i < 3; i++) begin
      wr(hco_pkg::IDX_FG_STACK, fg[8*i+:8]);
      wr(hco_pkg::IDX_BG_STACK, bg[8*i+:8]);
    end
    rd(hco_pkg::IDX_FG_STACK, {16'h0000, fg[7:0]});
    men = 1;
    px = 70;
    py = 40;
    pox = 3;
    poy = 5;
    scan();
    frame();
    scan();
    wr(hco_pkg::IDX_CONV, 8'h10);
    conv = 1;
    scan();
    @(posedge ref_clk_in) enhanced_in <= 1'b0;
    scan();
    @(posedge ref_clk_in) {enhanced_in, legacy_mode_in} <= 2'h3;
    scan();
    @(posedge ref_clk_in) legacy_mode_in <= 1'b0;
    wr(hco_pkg::IDX_LOCK, hco_pkg::LOCK_KEY);
    wr(hco_pkg::IDX_MODE, 8'h00);
    scan();
    wr(hco_pkg::IDX_LOCK, hco_pkg::UNLOCK_KEY);
    wr(hco_pkg::IDX_MODE, 8'h00);
    men = 0;
    scan();
    wr(hco_pkg::IDX_MODE, 8'h01);
    men = 1;
    wr(hco_pkg::IDX_Y_HIGH, 8'h04);
    py = 1064;
    frame();
    scan();
    stop_test();
  end
endmodule

`default_nettype wire
